//--- bench/uie_host_model.sv
// Avalon-MM host that stands in for the processor on the register bus.
// Assumes a slave that samples requests on the rising edge of clock_i.
`timescale 1ns/1ps
module uie_host_model (
    // Clock
    input wire logic clock_i,
    // Slave answer
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    // Request
    output logic [5:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o
);
    initial begin
        {address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
    end

    // The request is held until waitrequest is seen low; only the bench watchdog ends a hang.
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        @(posedge clock_i);
        address_o <= a;
        read_o <= !wr;
        write_o <= wr;
        writedata_o <= d;
        byteenable_o <= be;
        do @(posedge clock_i); while (waitrequest_i !== 1'b0);
        q = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
endmodule

//--- bench/uie_monitor.sv
// Assertion checker for the UART interrupt block, bound to its top module.
// Assumes the register offsets of the shared defines and a single clock.
`timescale 1ns/1ps
`include "uie_defines.svh"
module uie_monitor
    import uie_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Datapath side
    input wire uie_tx_type tx_i,
    input wire logic enhanced_en_i,
    input wire logic rx_pop_o,
    input wire logic txh_write_o,
    input wire logic [7:0] txh_data_o,
    input wire logic rx_fifo_reset_o,
    input wire logic fifo_en_o,
    input wire logic sleep_en_o,
    input wire logic polled_mode_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic done;
    logic rd_ist;
    logic wr_txh;
    logic wr_fctl;
    assign done = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign rd_ist = done && avs_read_i && avs_address_i == `UIE_OFF_IST;
    assign wr_txh = done && avs_write_i && avs_byteenable_i[0] && avs_address_i == `UIE_OFF_TXH;
    assign wr_fctl = done && avs_write_i && avs_byteenable_i[0] &&
                     avs_address_i == `UIE_OFF_FCTL;

    AST_ONE_WAIT: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state count wrong");
    AST_IST_FIFO: assert property (rd_ist |-> avs_readdata_o[7:6] == {2{fifo_en_o}})
        else $error("status fifo bits wrong");
    AST_IST_CODE: assert property (rd_ist |-> avs_readdata_o[4:0] inside
        {5'h06, 5'h0C, 5'h04, 5'h02, 5'h00, 5'h10, 5'h01}) else $error("bad status code");
    AST_IST_IDLE: assert property (rd_ist && avs_readdata_o[0] |->
        avs_readdata_o[4:1] == 4'h0) else $error("idle code wrong");
    AST_LST_TX: assert property (done && avs_read_i && avs_address_i == `UIE_OFF_LST |->
        avs_readdata_o[6:5] == $past({tx_i.all_empty, tx_i.txh_empty}))
        else $error("line status transmit bits wrong");
    AST_POP: assert property (rx_pop_o |-> done && avs_read_i &&
        avs_address_i == `UIE_OFF_RXH) else $error("pop without data read");
    AST_TXH: assert property (wr_txh |=> txh_write_o &&
        txh_data_o == $past(avs_writedata_i[7:0])) else $error("holding write lost");
    AST_TXH_CAUSE: assert property (txh_write_o |-> $past(wr_txh))
        else $error("spurious holding write");
    AST_FCTL_EN: assert property (wr_fctl |=> fifo_en_o == $past(avs_writedata_i[0]))
        else $error("fifo enable not written");
    AST_FIFO_HOLD: assert property (fifo_en_o != $past(fifo_en_o) |-> $past(wr_fctl))
        else $error("fifo enable changed alone");
    AST_RX_RST: assert property (rx_fifo_reset_o |->
        $past(wr_fctl && avs_writedata_i[1:0] == 2'b11)) else $error("bad receive reset");
    AST_SLEEP: assert property (sleep_en_o |-> enhanced_en_i)
        else $error("sleep without enhanced mode");
    AST_POLL: assert property (polled_mode_o |-> fifo_en_o)
        else $error("polled mode without fifo");
    cover property (rd_ist && !avs_readdata_o[0]);
    cover property (rx_pop_o);
    cover property (txh_write_o);
    cover property ($fell(irq_o));
endmodule

//--- bench/uie_top_tb.sv
// Self-checking bench for the UART interrupt block driven through a host model.
// Assumes the register offsets of the shared defines.
`timescale 1ns/1ps
`include "uie_defines.svh"
module uie_top_tb
    import uie_pkg::*;
;
    logic clock_i;
    logic rst_i;
    logic [5:0] avs_address_i;
    logic avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    uie_rx_type rx_i;
    uie_tx_type tx_i;
    uie_modem_type modem_i;
    uie_flow_type flow_i;
    logic [7:0] rx_head_data_i, txh_data_o;
    logic enhanced_en_i, bit_tick_i;
    logic [3:0] char_bits_i;
    logic rx_pop_o, txh_write_o, rx_fifo_reset_o, tx_fifo_reset_o;
    logic fifo_en_o, sleep_en_o, polled_mode_o, irq_o;
    logic [31:0] q;
    int num_errors;
    int checked;

    uie_top uie_top_i (.*);
    uie_host_model uie_host_model_i (.clock_i(clock_i), .waitrequest_i(avs_waitrequest_o),
        .readdata_i(avs_readdata_o), .address_o(avs_address_i), .read_o(avs_read_i),
        .write_o(avs_write_i), .writedata_o(avs_writedata_i), .byteenable_o(avs_byteenable_i));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        uie_host_model_i.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(q[7:0], e);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        uie_host_model_i.xfer(1'b1, a, {24'h00_0000, d}, 4'hF, q);
    endtask

    task automatic gap;
        repeat (3) @(posedge clock_i);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock_i);
            bit_tick_i <= 1'b1;
            @(posedge clock_i);
            bit_tick_i <= 1'b0;
        end
    endtask

    task automatic complete_run;
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        complete_run;
    end

    initial begin
        {rst_i, rx_i, modem_i, flow_i, enhanced_en_i, bit_tick_i} = '0;
        rst_i = 1'b1;
        tx_i = 7'h60;
        rx_head_data_i = 8'h5A;
        char_bits_i = 4'hA;
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(`UIE_OFF_IEN, 8'h00);
        rd(`UIE_OFF_IST, 8'h01);
        rd(`UIE_OFF_FCTL, 8'h00);
        rd(6'h3C, 8'h00);
        uie_host_model_i.xfer(1'b1, `UIE_OFF_IEN, 32'h0000_000F, 4'hE, q);
        rd(`UIE_OFF_IEN, 8'h00);
        wr(`UIE_OFF_FCTL, 8'h46);
        gap;
        chk(fifo_en_o, 8'h00);
        wr(`UIE_OFF_FCTL, 8'h47);
        gap;
        chk(polled_mode_o, 8'h01);
        rd(`UIE_OFF_IST, 8'hC1);
        rd(`UIE_OFF_LST, 8'h60);
        // One character below the trigger of four leaves only the timer to report it.
        wr(`UIE_OFF_IEN, 8'h01);
        @(posedge clock_i);
        rx_i.level <= 5'h01;
        rx_i.push <= 1'b1;
        @(posedge clock_i);
        rx_i.push <= 1'b0;
        tick(51);
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        rd(`UIE_OFF_LST, 8'h61);
        tick(1);
        gap;
        rd(`UIE_OFF_IST, 8'hCC);
        chk(irq_o, 8'h01);
        rd(`UIE_OFF_RXH, 8'h5A);
        rx_i.level <= 5'h00;
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        chk(irq_o, 8'h00);
        wr(`UIE_OFF_IEN, 8'h05);
        @(posedge clock_i);
        rx_i.overrun <= 1'b1;
        @(posedge clock_i);
        rx_i.overrun <= 1'b0;
        rx_i.level <= 5'h04;
        rx_i.push <= 1'b1;
        @(posedge clock_i);
        rx_i.push <= 1'b0;
        gap;
        rd(`UIE_OFF_IST, 8'hC6);
        rd(`UIE_OFF_IST, 8'hC6);
        rd(`UIE_OFF_LST, 8'h63);
        gap;
        rd(`UIE_OFF_IST, 8'hC4);
        rx_i.level <= 5'h03;
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        rx_i.level <= 5'h00;
        wr(`UIE_OFF_IEN, 8'h02);
        gap;
        rd(`UIE_OFF_IST, 8'hC2);
        rd(`UIE_OFF_IST, 8'hC1);
        wr(`UIE_OFF_IEN, 8'h00);
        wr(`UIE_OFF_IEN, 8'h02);
        gap;
        chk(irq_o, 8'h01);
        wr(`UIE_OFF_TXH, 8'hA5);
        tx_i.txh_empty <= 1'b0;
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        chk(irq_o, 8'h00);
        wr(`UIE_OFF_IEN, 8'h08);
        @(posedge clock_i);
        modem_i <= 8'h31;
        @(posedge clock_i);
        modem_i.delta <= 4'h0;
        gap;
        rd(`UIE_OFF_IST, 8'hC0);
        // Modem status reads lines in the high nibble and deltas in the low one.
        rd(`UIE_OFF_MST, 8'h13);
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        enhanced_en_i <= 1'b1;
        wr(`UIE_OFF_IEN, 8'h30);
        gap;
        chk(sleep_en_o, 8'h01);
        @(posedge clock_i);
        flow_i.xoff <= 1'b1;
        @(posedge clock_i);
        flow_i.xoff <= 1'b0;
        gap;
        rd(`UIE_OFF_IST, 8'hD0);
        rd(`UIE_OFF_IST, 8'hC1);
        @(posedge clock_i);
        flow_i.flow_deassert <= 1'b1;
        @(posedge clock_i);
        flow_i.flow_deassert <= 1'b0;
        gap;
        rd(`UIE_OFF_IST, 8'hE1);
        rd(`UIE_OFF_IST, 8'hC1);
        // Wake-up shows the idle code yet still drives the interrupt output.
        @(posedge clock_i);
        flow_i.wake <= 1'b1;
        @(posedge clock_i);
        flow_i.wake <= 1'b0;
        gap;
        chk(irq_o, 8'h01);
        rd(`UIE_OFF_IST, 8'hC1);
        gap;
        chk(irq_o, 8'h00);
        @(posedge clock_i);
        flow_i.xoff <= 1'b1;
        @(posedge clock_i);
        flow_i.xoff <= 1'b0;
        flow_i.xon <= 1'b1;
        @(posedge clock_i);
        flow_i.xon <= 1'b0;
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        @(posedge clock_i);
        flow_i.special <= 1'b1;
        @(posedge clock_i);
        flow_i.special <= 1'b0;
        gap;
        chk(irq_o, 8'h01);
        rx_i.push <= 1'b1;
        @(posedge clock_i);
        rx_i.push <= 1'b0;
        gap;
        chk(irq_o, 8'h00);
        // A parity error flags the line interrupt only once its byte is read out.
        wr(`UIE_OFF_IEN, 8'h04);
        @(posedge clock_i);
        rx_i.parity_err <= 1'b1;
        rx_i.fifo_error <= 1'b1;
        rx_i.level <= 5'h01;
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        rd(`UIE_OFF_RXH, 8'h5A);
        gap;
        rd(`UIE_OFF_IST, 8'hC6);
        rd(`UIE_OFF_LST, 8'hC5);
        gap;
        rd(`UIE_OFF_IST, 8'hC1);
        rx_i <= '0;
        wr(`UIE_OFF_FCTL, 8'h00);
        rd(`UIE_OFF_IST, 8'h01);
        complete_run;
    end
endmodule

bind uie_top uie_monitor uie_monitor_i (.*);

//--- hdl/uie_defines.svh
// Offsets, field positions, reset values and timing counts for the UART interrupt block.
// Assumes a 32-bit Avalon-MM register window with one register per aligned word.
`ifndef UIE_DEFINES_SVH
`define UIE_DEFINES_SVH

`define UIE_OFF_IEN 6'h00
`define UIE_OFF_IST 6'h04
`define UIE_OFF_FCTL 6'h08
`define UIE_OFF_LST 6'h0C
`define UIE_OFF_MST 6'h10
`define UIE_OFF_RXH 6'h14
`define UIE_OFF_TXH 6'h18

`define UIE_IEN_RESET 8'h00
`define UIE_FCTL_RESET 8'h00

`define UIE_IEN_RX 0
`define UIE_IEN_TX 1
`define UIE_IEN_LS 2
`define UIE_IEN_MS 3
`define UIE_IEN_SLEEP 4
`define UIE_IEN_XOFF 5
`define UIE_FCTL_EN 0
`define UIE_FCTL_RXRST 1
`define UIE_FCTL_TXRST 2

`define UIE_IST_LS 6'h06
`define UIE_IST_TMO 6'h0C
`define UIE_IST_RXR 6'h04
`define UIE_IST_TXR 6'h02
`define UIE_IST_MS 6'h00
`define UIE_IST_XOFF 6'h10
`define UIE_IST_NONE 6'h01
`define UIE_IST_FLOW 5

`define UIE_TMO_CHARS 7'h04
`define UIE_TMO_BITS 7'h0C

`endif

//--- hdl/uie_pkg.sv
// Types shared by the UART interrupt block and its surroundings.
// Assumes the receive and transmit datapaths report on the same clock.
package uie_pkg;

    typedef enum logic [2:0] {
        UIE_LV_NONE = 3'b000,
        UIE_LV_LS   = 3'b001,
        UIE_LV_TMO  = 3'b010,
        UIE_LV_RXR  = 3'b011,
        UIE_LV_TXR  = 3'b100,
        UIE_LV_MS   = 3'b101,
        UIE_LV_XOFF = 3'b110,
        UIE_LV_WAKE = 3'b111
    } uie_level_type;

    typedef struct packed {
        logic       push;
        logic       overrun;
        logic       parity_err;
        logic       framing_err;
        logic       break_err;
        logic       fifo_error;
        logic [4:0] level;
    } uie_rx_type;

    typedef struct packed {
        logic       txh_empty;
        logic       all_empty;
        logic [4:0] level;
    } uie_tx_type;

    typedef struct packed {
        logic [3:0] delta;
        logic [3:0] lines;
    } uie_modem_type;

    typedef struct packed {
        logic xoff;
        logic xon;
        logic special;
        logic flow_deassert;
        logic wake;
    } uie_flow_type;

endpackage

//--- hdl/uie_top.sv
// Interrupt enable, status and priority logic of a single-channel UART.
// Assumes the datapaths, baud generator and flow matcher share clock_i and report
// events as one-cycle pulses; the host reaches registers over Avalon-MM.
`timescale 1ns/1ps
`include "uie_defines.svh"

module uie_top
    import uie_pkg::*;
#(
    parameter int LEVEL_W = 5
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Avalon-MM slave
    input  wire logic [5:0] avs_address_i,
    input  wire logic avs_read_i,
    input  wire logic avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Datapath status
    input  wire uie_rx_type rx_i,
    input  wire logic [7:0] rx_head_data_i,
    input  wire uie_tx_type tx_i,
    input  wire uie_modem_type modem_i,
    input  wire uie_flow_type flow_i,
    input  wire logic enhanced_en_i,
    input  wire logic bit_tick_i,
    input  wire logic [3:0] char_bits_i,
    // Datapath controls
    output logic rx_pop_o,
    output logic txh_write_o,
    output logic [7:0] txh_data_o,
    output logic rx_fifo_reset_o,
    output logic tx_fifo_reset_o,
    output logic fifo_en_o,
    output logic sleep_en_o,
    output logic polled_mode_o,
    // Interrupt
    output logic irq_o
);

    logic ack;
    logic [7:0] int_en;
    logic [7:0] fifo_ctl;
    logic overrun;
    logic [3:0] modem_delta;
    logic ls_irq;
    logic tmo_irq;
    logic tx_irq;
    logic tx_cond_q;
    logic en_tx_q;
    logic xoff_irq;
    logic special_irq;
    logic flow_flag;
    logic wake_irq;
    logic [6:0] tmo_cnt;
    uie_level_type cur;
    uie_level_type next_cur;
    logic [5:0] ist_code;
    logic [7:0] ist_val;
    logic [7:0] lst_val;
    logic [31:0] next_rdata;
    logic do_rd;
    logic do_wr;
    logic rd_ist;
    logic rd_lst;
    logic rd_mst;
    logic rd_rxh;
    logic wr_txh;
    logic wr_fctl;
    logic enh_on;
    logic rx_ready;
    logic tx_cond;
    logic [6:0] tmo_limit;
    logic [6:0] pend;

    function automatic logic [LEVEL_W-1:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'b00: trig_level = LEVEL_W'(1);
            2'b01: trig_level = LEVEL_W'(4);
            2'b10: trig_level = LEVEL_W'(8);
            default: trig_level = LEVEL_W'(14);
        endcase
    endfunction

    // Each access is answered on its second edge; side effects land only then.
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign do_rd = avs_read_i & ack;
    assign do_wr = avs_write_i & ack & avs_byteenable_i[0];
    assign rd_ist = do_rd && (avs_address_i == `UIE_OFF_IST);
    assign rd_lst = do_rd && (avs_address_i == `UIE_OFF_LST);
    assign rd_mst = do_rd && (avs_address_i == `UIE_OFF_MST);
    assign rd_rxh = do_rd && (avs_address_i == `UIE_OFF_RXH);
    assign wr_txh = do_wr && (avs_address_i == `UIE_OFF_TXH);
    assign wr_fctl = do_wr && (avs_address_i == `UIE_OFF_FCTL);

    assign enh_on = enhanced_en_i;
    assign fifo_en_o = fifo_ctl[`UIE_FCTL_EN];
    assign sleep_en_o = int_en[`UIE_IEN_SLEEP] & enh_on;
    assign polled_mode_o = fifo_ctl[`UIE_FCTL_EN] & (int_en[3:0] == 4'h0);
    assign rx_pop_o = rd_rxh;
    assign tmo_limit = 7'(`UIE_TMO_CHARS * {3'h0, char_bits_i}) + `UIE_TMO_BITS;

    // Level sources are live so they follow the FIFO without a latch.
    assign rx_ready = fifo_ctl[`UIE_FCTL_EN] ? (rx_i.level >= trig_level(fifo_ctl[7:6]))
                                            : (rx_i.level != '0);
    assign tx_cond = fifo_ctl[`UIE_FCTL_EN] ?
                     ((tx_i.level < trig_level(fifo_ctl[5:4])) | tx_i.all_empty)
                     : tx_i.txh_empty;

    // Pending and enabled (wake-up has no enable), in priority order from level 1 down.
    always_comb begin
        pend[0] = ls_irq & int_en[`UIE_IEN_LS];
        pend[1] = tmo_irq & int_en[`UIE_IEN_RX];
        pend[2] = rx_ready & int_en[`UIE_IEN_RX];
        pend[3] = tx_irq & int_en[`UIE_IEN_TX];
        pend[4] = (modem_delta != 4'h0) & int_en[`UIE_IEN_MS];
        pend[5] = (xoff_irq | special_irq) & int_en[`UIE_IEN_XOFF] & enh_on;
        pend[6] = wake_irq;
    end

    // A reported source stays reported until it is cleared or disabled; no other source displaces it.
    always_comb begin
        next_cur = cur;
        case (cur)
            UIE_LV_LS: if (!pend[0]) next_cur = UIE_LV_NONE;
            UIE_LV_TMO: if (!pend[1]) next_cur = UIE_LV_NONE;
            UIE_LV_RXR: if (!pend[2]) next_cur = UIE_LV_NONE;
            UIE_LV_TXR: if (!pend[3]) next_cur = UIE_LV_NONE;
            UIE_LV_MS: if (!pend[4]) next_cur = UIE_LV_NONE;
            UIE_LV_XOFF: if (!pend[5]) next_cur = UIE_LV_NONE;
            UIE_LV_WAKE: if (!pend[6]) next_cur = UIE_LV_NONE;
            default: begin
                if (pend[0]) next_cur = UIE_LV_LS;
                else if (pend[1]) next_cur = UIE_LV_TMO;
                else if (pend[2]) next_cur = UIE_LV_RXR;
                else if (pend[3]) next_cur = UIE_LV_TXR;
                else if (pend[4]) next_cur = UIE_LV_MS;
                else if (pend[5]) next_cur = UIE_LV_XOFF;
                else if (pend[6]) next_cur = UIE_LV_WAKE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= UIE_LV_NONE;
        end else begin
            cur <= next_cur;
        end
    end

    always_comb begin
        case (cur)
            UIE_LV_LS: ist_code = `UIE_IST_LS;
            UIE_LV_TMO: ist_code = `UIE_IST_TMO;
            UIE_LV_RXR: ist_code = `UIE_IST_RXR;
            UIE_LV_TXR: ist_code = `UIE_IST_TXR;
            UIE_LV_MS: ist_code = `UIE_IST_MS;
            UIE_LV_XOFF: ist_code = `UIE_IST_XOFF;
            default: ist_code = `UIE_IST_NONE;
        endcase
        ist_val = {{2{fifo_ctl[`UIE_FCTL_EN]}}, ist_code};
        if (enh_on && flow_flag) begin
            ist_val[`UIE_IST_FLOW] = 1'b1;
        end
        lst_val = {rx_i.fifo_error, tx_i.all_empty, tx_i.txh_empty, rx_i.break_err,
                   rx_i.framing_err, rx_i.parity_err, overrun, rx_i.level != '0};
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (avs_address_i)
            `UIE_OFF_IEN: next_rdata[7:0] = int_en;
            `UIE_OFF_IST: next_rdata[7:0] = ist_val;
            `UIE_OFF_LST: next_rdata[7:0] = lst_val;
            `UIE_OFF_MST: next_rdata[7:0] = {modem_i.lines, modem_delta};
            `UIE_OFF_RXH: next_rdata[7:0] = rx_head_data_i;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
            if (avs_read_i && !ack) begin
                avs_readdata_o <= next_rdata;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            int_en <= `UIE_IEN_RESET;
        end else if (do_wr && avs_address_i == `UIE_OFF_IEN) begin
            int_en <= avs_writedata_i[7:0];
        end
    end

    // Enhanced trigger bits are kept out unless the enhanced enable is on.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fifo_ctl <= `UIE_FCTL_RESET;
            rx_fifo_reset_o <= 1'b0;
            tx_fifo_reset_o <= 1'b0;
        end else begin
            rx_fifo_reset_o <= 1'b0;
            tx_fifo_reset_o <= 1'b0;
            if (wr_fctl) begin
                fifo_ctl[`UIE_FCTL_EN] <= avs_writedata_i[`UIE_FCTL_EN];
                if (avs_writedata_i[`UIE_FCTL_EN]) begin
                    fifo_ctl[7:6] <= avs_writedata_i[7:6];
                    fifo_ctl[3:1] <= avs_writedata_i[3:1];
                    if (enh_on) begin
                        fifo_ctl[5:4] <= avs_writedata_i[5:4];
                    end
                    rx_fifo_reset_o <= avs_writedata_i[`UIE_FCTL_RXRST];
                    tx_fifo_reset_o <= avs_writedata_i[`UIE_FCTL_TXRST];
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            txh_write_o <= 1'b0;
            txh_data_o <= 8'h00;
        end else begin
            txh_write_o <= wr_txh;
            if (wr_txh) begin
                txh_data_o <= avs_writedata_i[7:0];
            end
        end
    end

    // Overrun flags at once; other errors flag as the bad byte leaves the FIFO.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
            ls_irq <= 1'b0;
        end else begin
            if (rx_i.overrun) begin
                overrun <= 1'b1;
            end else if (rd_lst) begin
                overrun <= 1'b0;
            end
            if (rx_i.overrun ||
                (rd_rxh && (rx_i.parity_err || rx_i.framing_err || rx_i.break_err))) begin
                ls_irq <= 1'b1;
            end else if (rd_lst) begin
                ls_irq <= 1'b0;
            end
        end
    end

    // Restarts on any FIFO movement so only a stalled, non-empty FIFO times out.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_cnt <= 7'h00;
            tmo_irq <= 1'b0;
        end else begin
            if (rx_i.push || rd_rxh || !fifo_ctl[`UIE_FCTL_EN] || rx_i.level == '0) begin
                tmo_cnt <= 7'h00;
            end else if (bit_tick_i && tmo_cnt < tmo_limit) begin
                tmo_cnt <= tmo_cnt + 7'h01;
            end
            if (bit_tick_i && tmo_cnt == tmo_limit - 7'h01 && !rx_i.push && !rd_rxh &&
                fifo_ctl[`UIE_FCTL_EN] && rx_i.level != '0) begin
                tmo_irq <= 1'b1;
            end else if (rd_rxh) begin
                tmo_irq <= 1'b0;
            end
        end
    end

    // Edge of the empty condition, or the enable rising while already empty.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_cond_q <= 1'b0;
            en_tx_q <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            tx_cond_q <= tx_cond;
            en_tx_q <= int_en[`UIE_IEN_TX];
            if ((tx_cond && !tx_cond_q) || (tx_cond && int_en[`UIE_IEN_TX] && !en_tx_q)) begin
                tx_irq <= 1'b1;
            end else if (wr_txh || (rd_ist && cur == UIE_LV_TXR)) begin
                tx_irq <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            modem_delta <= 4'h0;
        end else begin
            modem_delta <= (rd_mst ? 4'h0 : modem_delta) | modem_i.delta;
        end
    end

    // Status-read clears only hit the source being reported in that read, except flow_flag, which any status read clears.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            xoff_irq <= 1'b0;
            special_irq <= 1'b0;
            flow_flag <= 1'b0;
            wake_irq <= 1'b0;
        end else begin
            if (flow_i.xoff) begin
                xoff_irq <= 1'b1;
            end else if (flow_i.xon || (rd_ist && cur == UIE_LV_XOFF)) begin
                xoff_irq <= 1'b0;
            end
            if (flow_i.special) begin
                special_irq <= 1'b1;
            end else if (rx_i.push || (rd_ist && cur == UIE_LV_XOFF)) begin
                special_irq <= 1'b0;
            end
            if (flow_i.flow_deassert) begin
                flow_flag <= 1'b1;
            end else if (rd_ist) begin
                flow_flag <= 1'b0;
            end
            if (flow_i.wake) begin
                wake_irq <= 1'b1;
            end else if (rd_ist && cur == UIE_LV_WAKE) begin
                wake_irq <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |pend;
        end
    end

endmodule
